// >>> shared/spb_cfg.svh
// constants for the serial port b control block
// How it works
// - async modes frame data with one start and one stop bit
// - top three control bits pick mode 0 to 3 plus qualifier
// - mode 0 shifts eight bits, 12 or 4 peripheral clocks per bit
// - mode 1 sends ten-bit frames at the timer baud tick rate
// - mode 2 sends eleven-bit frames, 64 or 32 clocks per bit
// - mode 3 sends eleven-bit frames at the timer baud tick rate
// - modes 2 and 3 with qualifier drop frames whose ninth bit is zero
// - mode 1 with qualifier flags a byte only on a valid stop bit
// - everything but a mode 0 receive start advances only on the peripheral clock enable, stopped in idle
// - receive enable clear stops the receiver; set enables modes 1 to 3
// - setting receive enable in mode 0 starts one synchronous byte in
// - modes 2 and 3 send the ninth transmit bit as ninth data bit
// - ninth received bit stored in modes 2, 3; stop bit in mode 1
// - transmit done sets after the eighth or last data bit
// - receive done sets after bit eight, stop sample or ninth sample
// - buffer address: writes feed transmitter, reads give receive buffer
`ifndef SPB_CFG_SVH
`define SPB_CFG_SVH
`define SPB_CTRL_ADDR    8'hc0
`define SPB_BUF_ADDR     8'hc1
`define SPB_CTRL_RESET   8'h00
`define SPB_BIT_MHI      7
`define SPB_BIT_MLO      6
`define SPB_BIT_MPQ      5
`define SPB_BIT_REN      4
`define SPB_BIT_TB8      3
`define SPB_BIT_RB8      2
`define SPB_BIT_TXDONE   1
`define SPB_BIT_RXDONE   0
`define SPB_M0_SLOW_PCLK 12
`define SPB_M0_FAST_PCLK 4
`define SPB_M2_SLOW_PCLK 64
`define SPB_M2_FAST_PCLK 32
`define SPB_OVERSAMPLE   16
`define SPB_SAMPLE_POINT 4'h7
`define SPB_SYNC_LAST    4'h7
`define SPB_RX_LAST      4'h9
`define SPB_TX_LAST_M1   4'h9
`define SPB_TX_LAST_M23  4'ha
`define SPB_FIFO_DEPTH   16
`endif

// >>> shared/spb_pkg.sv
// types for the serial port b control block
package spb_pkg;
    typedef enum logic [1:0] {SPB_IDLE, SPB_ASYNC, SPB_SYNC} spb_state_e;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  rxBuf;
        logic [7:0]  rdData;
        logic        txd;
        logic        rxdOut;
        logic        rxdOe;
        logic        fifoRdy;
        logic [3:0]  divCnt;
        spb_state_e  txSt;
        logic [3:0]  txTick;
        logic [3:0]  txBit;
        logic [10:0] txSh;
        spb_state_e  rxSt;
        logic [3:0]  rxTick;
        logic [3:0]  rxBit;
        logic [8:0]  rxSh;
        logic        rxPrev;
    } spb_state_s;
endpackage : spb_pkg

// >>> rtl/spb_serial_port.sv
// serial port b control logic with transmit fifo
`timescale 1ns/10ps
`include "spb_cfg.svh"

// ************************************************
// transmit fifo
// ************************************************
module spb_fifo
    import spb_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SPB_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   count;
    } spb_fifo_s;

    logic [WIDTH-1:0] mem [DEPTH];
    spb_fifo_s        s;
    spb_fifo_s        n;
    logic             push;
    logic             pop;

    assign inReady  = s.count != (AW+1)'(DEPTH);
    assign outValid = s.count != '0;
    assign outData  = mem[s.rdPtr];

    always_comb begin
        n    = s;
        push = inValid && inReady;
        pop  = outValid && outReady;
        if (push) begin
            n.wrPtr = (s.wrPtr == AW'(DEPTH-1)) ? '0 : s.wrPtr + 1'b1;
        end
        if (pop) begin
            n.rdPtr = (s.rdPtr == AW'(DEPTH-1)) ? '0 : s.rdPtr + 1'b1;
        end
        n.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[s.wrPtr] <= inData;
        end
    end
endmodule : spb_fifo

// ************************************************
// serial port b
// ************************************************
module spb_serial_port
    import spb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pclkEn,
    input  wire logic       baudDouble,
    input  wire logic       baudTick,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic       sfrRdEn,
    input  wire logic [7:0] sfrWrData,
    output logic      [7:0] sfrRdData,
    output logic            txd,
    input  wire logic       rxdIn,
    output logic            rxdOut,
    output logic            rxdOe,
    output logic            txFifoReady
);
    spb_state_s s;
    spb_state_s n;
    logic [1:0] mode;
    logic       wrCtrl;
    logic       wrBuf;
    logic       divTick;
    logic       sampTick;
    logic       popTx;
    logic       rxFin;
    logic       rxLoad;
    logic       m0Start;
    logic [3:0] txLast;
    logic       fInReady;
    logic       fOutValid;
    logic [7:0] fOutData;

    function automatic logic [3:0] divLimit(input logic [1:0] m, input logic q, input logic d);
        int p;
        if (m == 2'd0) begin
            p = (q ? `SPB_M0_FAST_PCLK : `SPB_M0_SLOW_PCLK) / 2;
        end else begin
            p = (d ? `SPB_M2_FAST_PCLK : `SPB_M2_SLOW_PCLK) / `SPB_OVERSAMPLE;
        end
        return 4'(p - 1);
    endfunction : divLimit

    spb_fifo #(
        .WIDTH (8),
        .DEPTH (`SPB_FIFO_DEPTH)
    ) txFifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inValid  (wrBuf),
        .inReady  (fInReady),
        .inData   (sfrWrData),
        .outValid (fOutValid),
        .outReady (popTx),
        .outData  (fOutData)
    );

    always_comb begin
        n        = s;
        mode     = {s.ctrl[`SPB_BIT_MHI], s.ctrl[`SPB_BIT_MLO]};
        wrCtrl   = sfrWrEn && (sfrAddr == `SPB_CTRL_ADDR);
        wrBuf    = sfrWrEn && (sfrAddr == `SPB_BUF_ADDR);
        divTick  = 1'b0;
        rxFin    = 1'b0;
        rxLoad   = 1'b0;
        txLast   = (mode == 2'd1) ? `SPB_TX_LAST_M1 : `SPB_TX_LAST_M23;
        n.rxPrev = rxdIn;
        if (wrCtrl) begin
            n.ctrl = sfrWrData;
        end
        m0Start  = wrCtrl && sfrWrData[`SPB_BIT_REN] && !s.ctrl[`SPB_BIT_REN]
                   && (sfrWrData[`SPB_BIT_MHI:`SPB_BIT_MLO] == 2'd0)
                   && !sfrWrData[`SPB_BIT_RXDONE] && (s.rxSt == SPB_IDLE);
        if (sfrRdEn) begin
            n.rdData = (sfrAddr == `SPB_CTRL_ADDR) ? s.ctrl :
                       (sfrAddr == `SPB_BUF_ADDR) ? s.rxBuf : 8'h00;
        end
        // all engines step on the peripheral clock enable
        if (pclkEn) begin
            if (s.divCnt >= divLimit(mode, s.ctrl[`SPB_BIT_MPQ], baudDouble)) begin
                n.divCnt = '0;
                divTick  = 1'b1;
            end else begin
                n.divCnt = s.divCnt + 4'h1;
            end
        end
        // timer tick paces modes 1 and 3
        sampTick = (mode == 2'd2) ? divTick : (baudTick && pclkEn);
        // next byte waits for a cleared done flag
        popTx    = pclkEn && fOutValid && (s.txSt == SPB_IDLE)
                   && !s.ctrl[`SPB_BIT_TXDONE] && (s.rxSt != SPB_SYNC);

        // ********************************
        // transmitter
        // ********************************
        case (s.txSt)
            SPB_IDLE: begin
                if (popTx) begin
                    // buffer data starts a new character
                    n.txTick = '0;
                    n.txBit  = '0;
                    n.divCnt = '0;
                    if (mode == 2'd0) begin
                        n.txSt = SPB_SYNC;
                        n.txSh = {3'b111, fOutData};
                    end else begin
                        n.txSt = SPB_ASYNC;
                        // start, data, ninth or stop, stop
                        n.txSh = (mode == 2'd1) ? {2'b11, fOutData, 1'b0}
                               : {1'b1, s.ctrl[`SPB_BIT_TB8], fOutData, 1'b0};
                    end
                end
            end
            SPB_ASYNC: begin
                if (sampTick) begin
                    n.txTick = s.txTick + 4'h1;
                    if (s.txTick == 4'(`SPB_OVERSAMPLE - 1)) begin
                        n.txSh  = {1'b1, s.txSh[10:1]};
                        n.txBit = s.txBit + 4'h1;
                        // done at end of last data bit
                        if (s.txBit == txLast - 4'h1) begin
                            n.ctrl[`SPB_BIT_TXDONE] = 1'b1;
                        end
                        if (s.txBit == txLast) begin
                            n.txSt = SPB_IDLE;
                        end
                    end
                end
            end
            SPB_SYNC: begin
                if (divTick) begin
                    n.txTick[0] = !s.txTick[0];
                    if (s.txTick[0]) begin
                        n.txSh  = {1'b1, s.txSh[10:1]};
                        n.txBit = s.txBit + 4'h1;
                        if (s.txBit == `SPB_SYNC_LAST) begin
                            n.ctrl[`SPB_BIT_TXDONE] = 1'b1;
                            n.txSt = SPB_IDLE;
                        end
                    end
                end
            end
            default: n.txSt = SPB_IDLE;
        endcase

        // ********************************
        // receiver
        // ********************************
        case (s.rxSt)
            SPB_IDLE: begin
                if (m0Start) begin
                    n.rxSt   = SPB_SYNC;
                    n.rxTick = '0;
                    n.rxBit  = '0;
                    n.divCnt = '0;
                end else if (pclkEn && s.ctrl[`SPB_BIT_REN] && mode != 2'd0
                             && s.rxPrev && !rxdIn) begin
                    n.rxSt   = SPB_ASYNC;
                    n.rxTick = '0;
                    n.rxBit  = '0;
                end
            end
            SPB_ASYNC: begin
                if (sampTick) begin
                    n.rxTick = s.rxTick + 4'h1;
                    if (s.rxTick == `SPB_SAMPLE_POINT) begin
                        n.rxBit = s.rxBit + 4'h1;
                        if (s.rxBit == 4'h0) begin
                            if (rxdIn) begin
                                n.rxSt = SPB_IDLE;
                            end
                        end else begin
                            n.rxSh = {rxdIn, s.rxSh[8:1]};
                            if (s.rxBit == `SPB_RX_LAST) begin
                                rxFin  = 1'b1;
                                n.rxSt = SPB_IDLE;
                                // held until the done flag is cleared
                                rxLoad = !s.ctrl[`SPB_BIT_RXDONE]
                                         && (!s.ctrl[`SPB_BIT_MPQ] || rxdIn);
                                if (rxLoad) begin
                                    n.rxBuf = s.rxSh[8:1];
                                    n.ctrl[`SPB_BIT_RB8] = rxdIn;
                                    n.ctrl[`SPB_BIT_RXDONE] = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
            SPB_SYNC: begin
                if (divTick) begin
                    n.rxTick[0] = !s.rxTick[0];
                    if (!s.rxTick[0]) begin
                        n.rxSh = {rxdIn, s.rxSh[8:1]};
                    end else begin
                        n.rxBit = s.rxBit + 4'h1;
                        if (s.rxBit == `SPB_SYNC_LAST) begin
                            rxFin  = 1'b1;
                            rxLoad = 1'b1;
                            n.rxSt = SPB_IDLE;
                            n.rxBuf = s.rxSh[8:1];
                            n.ctrl[`SPB_BIT_RXDONE] = 1'b1;
                        end
                    end
                end
            end
            default: n.rxSt = SPB_IDLE;
        endcase
        // receive enable clear stops the receiver
        if (!n.ctrl[`SPB_BIT_REN]) begin
            n.rxSt = SPB_IDLE;
        end

        // ********************************
        // pins
        // ********************************
        n.rxdOe  = n.txSt == SPB_SYNC;
        n.rxdOut = n.txSt == SPB_SYNC ? n.txSh[0] : 1'b1;
        n.txd    = (n.txSt == SPB_SYNC) ? n.txTick[0] :
                   (n.rxSt == SPB_SYNC) ? n.rxTick[0] :
                   (n.txSt == SPB_ASYNC) ? n.txSh[0] : 1'b1;
        n.fifoRdy = fInReady || popTx;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s         <= '0;
            s.ctrl    <= `SPB_CTRL_RESET;
            s.txd     <= 1'b1;
            s.rxdOut  <= 1'b1;
            s.fifoRdy <= 1'b1;
            s.rxPrev  <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign sfrRdData   = s.rdData;
    assign txd         = s.txd;
    assign rxdOut      = s.rxdOut;
    assign rxdOe       = s.rxdOe;
    assign txFifoReady = s.fifoRdy;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence sAsyncLoad;
        popTx && mode != 2'd0;
    endsequence
    sequence sWrBufOnly;
        wrBuf && !rxLoad;
    endsequence

    a_frame_start_bit: assert property (sAsyncLoad |=> txd == 1'b0)
        else $error("async frame did not open with a low start bit");
    a_tx_ninth_bit: assert property ((sAsyncLoad and mode[1])
        |=> s.txSh[9] == $past(s.ctrl[`SPB_BIT_TB8]))
        else $error("ninth transmit bit not taken from control");
    a_idle_freeze: assert property (!pclkEn && !wrCtrl
        |=> $stable(s.txBit) && $stable(s.rxBit))
        else $error("engines moved while peripheral clock stopped");
    a_ren_off_idle: assert property (!s.ctrl[`SPB_BIT_REN] |-> s.rxSt == SPB_IDLE)
        else $error("receiver active with receive enable clear");
    a_m0_rx_start: assert property (m0Start |=> s.rxSt == SPB_SYNC)
        else $error("mode 0 receive did not start");
    a_mp_gate: assert property (rxFin && s.rxSt == SPB_ASYNC
        && s.ctrl[`SPB_BIT_MPQ] && !rxdIn |-> !rxLoad)
        else $error("frame with zero final bit accepted under qualifier");
    a_txdone_source: assert property ($rose(s.ctrl[`SPB_BIT_TXDONE])
        && !$past(wrCtrl) |-> $past(s.txSt) != SPB_IDLE)
        else $error("transmit done set without a transfer");
    a_buf_split: assert property (sWrBufOnly |=> $stable(s.rxBuf))
        else $error("buffer write disturbed the receive buffer");
    a_tx_starts: assert property (popTx |=> s.txSt != SPB_IDLE)
        else $error("popped byte did not start a character");
    a_rxdone_keep: assert property (s.ctrl[`SPB_BIT_RXDONE] && !wrCtrl
        |=> s.ctrl[`SPB_BIT_RXDONE] && $stable(s.rxBuf))
        else $error("receive done or buffer lost while pending");
endmodule : spb_serial_port

// >>> verification/spb_peer.sv
// remote serial peer model for serial port b
`timescale 1ns/10ps

module spb_peer (
    input  wire logic clk,
    input  wire logic txd,
    input  wire logic line,
    output logic      rxd
);
    // ****************************************
    // line drive, pulled up when released
    // ****************************************
    initial rxd = 1'b1;

    // start bit, lsb first, stop bit
    task automatic sendFrame(input logic [10:0] f, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            rxd = f[i];
            repeat (per) @(negedge clk);
        end
        rxd = 1'b1;
    endtask : sendFrame

    task automatic getFrame(input int n, input int per, output logic [10:0] f);
        f = '1;
        @(negedge txd);
        repeat (per / 2) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            f[i] = txd;
            repeat (per) @(negedge clk);
        end
    endtask : getFrame

    // shift clock low first, data taken on rise
    task automatic syncByte(input logic [7:0] d, output logic [7:0] q, output int per);
        realtime t0;
        t0 = 0.0;
        per = 0;
        for (int i = 0; i < 8; i++) begin
            // a receive clock may already be low at entry
            if (i > 0 || txd !== 1'b0) @(negedge txd);
            if (i == 2) per = int'(($realtime - t0) / 5.0);
            t0 = $realtime;
            rxd = d[i];
            @(posedge txd);
            q[i] = line;
        end
        rxd = 1'b1;
    endtask : syncByte
endmodule : spb_peer

// >>> verification/spb_serial_port_tb.sv
// self-checking bench for serial port b control
`timescale 1ns/10ps
`include "spb_cfg.svh"

module spb_serial_port_tb;
    logic       clk        = 1'b0;
    logic       rst_n      = 1'b0;
    logic       pclkEn     = 1'b1;
    logic       baudDouble = 1'b0;
    logic       baudTick   = 1'b0;
    logic [7:0] sfrAddr    = 8'h00;
    logic       sfrWrEn    = 1'b0;
    logic       sfrRdEn    = 1'b0;
    logic [7:0] sfrWrData  = 8'h00;
    logic [7:0] sfrRdData;
    logic       txd;
    logic       rxdOut;
    logic       rxdOe;
    logic       txFifoReady;
    logic       peerRxd;
    logic       rxdLine;
    int         failCount  = 0;
    int         checks     = 0;

    // ****************************************
    // clock, baud tick, shared data line
    // ****************************************
    always #2.5 clk = ~clk;
    always @(negedge clk) baudTick <= ~baudTick;
    assign rxdLine = rxdOe ? rxdOut : peerRxd;

    spb_serial_port dut (
        .clk        (clk),
        .rst_n      (rst_n),
        .pclkEn     (pclkEn),
        .baudDouble (baudDouble),
        .baudTick   (baudTick),
        .sfrAddr    (sfrAddr),
        .sfrWrEn    (sfrWrEn),
        .sfrRdEn    (sfrRdEn),
        .sfrWrData  (sfrWrData),
        .sfrRdData  (sfrRdData),
        .txd        (txd),
        .rxdIn      (rxdLine),
        .rxdOut     (rxdOut),
        .rxdOe      (rxdOe),
        .txFifoReady(txFifoReady)
    );

    spb_peer peer (
        .clk (clk),
        .txd (txd),
        .line(rxdLine),
        .rxd (peerRxd)
    );

    // ****************************************
    // bus access and compare
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        // idle edge first, strobe never re-raised in one step
        @(negedge clk);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(negedge clk);
        sfrWrEn = 1'b0;
    endtask : wr

    task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(negedge clk);
        sfrRdEn = 1'b0;
        @(negedge clk);
        cmp(11'(sfrRdData), 11'(exp));
    endtask : chkReg

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // ****************************************
    // scenarios
    // ****************************************
    task automatic asyncTx(input logic [7:0] c, input logic [7:0] d, input int n,
                           input int per, input logic [10:0] exp);
        logic [10:0] f;
        wr(`SPB_CTRL_ADDR, c);
        wr(`SPB_BUF_ADDR, d);
        peer.getFrame(n, per, f);
        cmp(f, exp);
        chkReg(`SPB_CTRL_ADDR, c | 8'h02);
    endtask : asyncTx

    task automatic asyncRx(input logic [7:0] c, input logic [10:0] f, input int n,
                           input logic [7:0] expCtrl, input logic [7:0] expBuf);
        wr(`SPB_CTRL_ADDR, c);
        peer.sendFrame(f, n, 32);
        repeat (4) @(negedge clk);
        chkReg(`SPB_CTRL_ADDR, expCtrl);
        chkReg(`SPB_BUF_ADDR, expBuf);
    endtask : asyncRx

    task automatic syncXfer(input logic [7:0] c, input logic [7:0] d, input int expPer,
                            input logic [7:0] expCtrl);
        logic [7:0] q;
        int per;
        wr(`SPB_CTRL_ADDR, c);
        if (c[`SPB_BIT_REN] == 1'b0) wr(`SPB_BUF_ADDR, d);
        peer.syncByte(d, q, per);
        cmp(11'(per), 11'(expPer));
        if (c[`SPB_BIT_REN] == 1'b0) cmp(11'(q), 11'(d));
        repeat (expPer) @(negedge clk);
        chkReg(`SPB_CTRL_ADDR, expCtrl);
        if (c[`SPB_BIT_REN]) chkReg(`SPB_BUF_ADDR, d);
    endtask : syncXfer

    task automatic fifoFill();
        logic [10:0] f;
        int n;
        n = 0;
        wr(`SPB_CTRL_ADDR, 8'h82);
        while (txFifoReady === 1'b1 && n < 20) begin
            wr(`SPB_BUF_ADDR, 8'(n));
            @(negedge clk);
            n++;
        end
        cmp(11'(n), 11'(`SPB_FIFO_DEPTH));
        cmp(11'(txd), 11'h1);
        for (int i = 0; i < n; i++) begin
            wr(`SPB_CTRL_ADDR, 8'h80);
            peer.getFrame(11, 32, f);
            cmp(f, {2'b10, 8'(i), 1'b0});
        end
        cmp(11'(txFifoReady), 11'h1);
    endtask : fifoFill

    task automatic idleTest();
        wr(`SPB_CTRL_ADDR, 8'h80);
        wr(`SPB_BUF_ADDR, 8'h00);
        repeat (10) @(negedge clk);
        pclkEn = 1'b0;
        repeat (400) @(negedge clk);
        cmp(11'(txd), 11'h0);
        chkReg(`SPB_CTRL_ADDR, 8'h80);
        pclkEn = 1'b1;
        repeat (400) @(negedge clk);
        chkReg(`SPB_CTRL_ADDR, 8'h82);
    endtask : idleTest

    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        chkReg(`SPB_CTRL_ADDR, `SPB_CTRL_RESET);
        chkReg(`SPB_BUF_ADDR, 8'h00);
        chkReg(8'h5e, 8'h00);
        cmp(11'(rxdOe), 11'h0);
        cmp(11'(txFifoReady), 11'h1);
        asyncTx(8'h88, 8'ha5, 11, 64, {2'b11, 8'ha5, 1'b0});
        baudDouble = 1'b1;
        asyncTx(8'h80, 8'h3c, 11, 32, {2'b10, 8'h3c, 1'b0});
        asyncTx(8'h40, 8'h69, 10, 32, {2'b11, 8'h69, 1'b0});
        asyncTx(8'he8, 8'h17, 11, 32, {2'b11, 8'h17, 1'b0});
        asyncRx(8'hb0, {2'b10, 8'h5a, 1'b0}, 11, 8'hb0, 8'h00);
        asyncRx(8'hb0, {2'b11, 8'h5a, 1'b0}, 11, 8'hb5, 8'h5a);
        asyncRx(8'h70, {2'b10, 8'hc3, 1'b0}, 10, 8'h70, 8'h5a);
        asyncRx(8'h50, {2'b11, 8'hc3, 1'b0}, 10, 8'h55, 8'hc3);
        asyncRx(8'h51, {2'b11, 8'h99, 1'b0}, 10, 8'h51, 8'hc3);
        asyncRx(8'h40, {2'b11, 8'h99, 1'b0}, 10, 8'h40, 8'hc3);
        asyncRx(8'hd0, {2'b10, 8'h81, 1'b0}, 11, 8'hd1, 8'h81);
        syncXfer(8'h00, 8'h96, `SPB_M0_SLOW_PCLK, 8'h02);
        syncXfer(8'h20, 8'h4b, `SPB_M0_FAST_PCLK, 8'h22);
        syncXfer(8'h10, 8'he7, `SPB_M0_SLOW_PCLK, 8'h11);
        fifoFill();
        idleTest();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk);
        failCount++;
        summarize();
    end
endmodule : spb_serial_port_tb
